// file: design/timer0_defines.svh
// register offsets, field positions, codes and reset values of the timer 0 control block
`ifndef TIMER0_DEFINES_SVH
`define TIMER0_DEFINES_SVH

// ==========================================
// register map (data-space offsets)
`define T0_OFS_FLAGS 8'h35
`define T0_OFS_GENCTL 8'h43
`define T0_OFS_CTLA 8'h44
`define T0_OFS_CTLB 8'h45
`define T0_OFS_COUNT 8'h46
`define T0_OFS_CMPA 8'h47
`define T0_OFS_CMPB 8'h48
`define T0_OFS_MASK 8'h6e
`define T0_IO_BIAS 8'h20
`define T0_IO_LIMIT 8'h40
`define T0_RESET_BYTE 8'h00

// ==========================================
// field positions
`define T0_B_FORCE_A 7
`define T0_B_FORCE_B 6
`define T0_B_WGM_HI 3
`define T0_F_CS 2:0
`define T0_F_WGM_LO 1:0
`define T0_F_COM_A 7:6
`define T0_F_COM_B 5:4
`define T0_B_TSM 7
`define T0_B_PSR_ASY 1
`define T0_B_PSR_SYNC 0
`define T0_F_IRQ 2:0
`define T0_B_OVF 0

// ==========================================
// codes
`define T0_CS_STOP 3'h0
`define T0_CS_DIV1 3'h1
`define T0_CS_DIV8 3'h2
`define T0_CS_DIV64 3'h3
`define T0_CS_DIV256 3'h4
`define T0_CS_DIV1024 3'h5
`define T0_CS_EXT_FALL 3'h6
`define T0_CS_EXT_RISE 3'h7
`define T0_WGM_CTC 3'h2
`define T0_WGM_LO_PHASE 2'h1
`define T0_WGM_LO_FAST 2'h3
`define T0_COM_TOGGLE 2'h1
`define T0_COM_CLEAR 2'h2
`define T0_COM_SET 2'h3
`define T0_MAX 8'hff
`define T0_BOTTOM 8'h00

// ==========================================
// prescaler taps (low bits all ones)
`define T0_PS_W 10
`define T0_TAP8 10'h007
`define T0_TAP64 10'h03f
`define T0_TAP256 10'h0ff
`define T0_TAP1024 10'h3ff
`define T0_PS_ZERO 10'h000
`define T0_PS_ONE 10'h001

`endif

// file: design/timer0_pkg.sv
// types shared by the timer 0 control block
package timer0_pkg;
   typedef struct packed {
      logic wrEn;
      logic rdEn;
      logic ioAccess;
      logic [7:0] addr;
      logic [7:0] wrData;
   } regReq_t;

   typedef struct packed {
      logic compareB;
      logic compareA;
      logic overflow;
   } irqVec_t;
endpackage : timer0_pkg

// file: design/timer0_ctrl.sv
// timer 0 counter, prescaler, compare channels and their register file
`timescale 1ns/1ps
`include "timer0_defines.svh"

// Operation
// - force strobes act only in non-PWM waveform modes, ignored in PWM.
// - force strobe applies an immediate match using current output mode bits.
// - forced match sets no flag, requests no interrupt, never clears counter.
// - force strobe bits always read back as zero.
// - clock select 0 stops; 1 undivided; 2..5 prescaler taps 8,64,256,1024.
// - clock select 6 counts falling, 7 rising edges of external pin.
// - external pin edges count even when the pin is an output.
// - overflow interrupt requested when flag, enable and global enable set.
// - compare interrupts requested when flag, own enable and global enable set.
// - with sync hold set, both prescaler reset bits keep their written values.
// - writing sync hold zero clears both reset bits; counters resume together.
// - async prescaler reset self-clears, waits in async mode, holds under sync hold.
// - sync prescaler reset clears shared prescaler, self-clears unless sync hold.
// - counter is read/write; a write blocks the match on next tick.
// - compare registers compared continuously; match drives flag and wave output.
// - registers decode at offset, below extended area also at offset minus 0x20.
// - writing one clears an interrupt flag, writing zero leaves it.
// - flags cleared on vector execution; compare flags set on match.
// - waveform mode selects normal, clear-on-match or two PWM kinds.
module timer0_ctrl (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic clkEn,
   input wire timer0_pkg::regReq_t busReq,
   input wire logic globalIrqEnable,
   input wire timer0_pkg::irqVec_t vectorAck,
   input wire logic asyncModeActive,
   input wire logic asyncResetDone,
   input wire logic extCountPin,
   output logic [7:0] regRdData,
   output timer0_pkg::irqVec_t irqReq,
   output logic waveOutA,
   output logic waveOutB,
   output logic asyncPrescalerRst,
   output logic syncPrescalerRst
);

   // ==========================================
   // register state
   logic [2:0] clockSel_r;
   logic waveModeHi_r;
   logic [1:0] waveModeLo_r;
   logic [1:0] compareMode_r [2];
   logic [7:0] compareValue_r [2];
   logic [7:0] count_r;
   logic countDown_r;
   logic blockMatch_r;
   timer0_pkg::irqVec_t irqFlags_r;
   timer0_pkg::irqVec_t irqMask_r;
   logic syncHold_r;
   logic [`T0_PS_W-1:0] prescale_r;
   logic extPrev_r;
   logic wave_r [2];

   // ==========================================
   // address decode
   logic [7:0] effAddr;
   logic addrOk;
   assign effAddr = busReq.ioAccess ? 8'(busReq.addr + `T0_IO_BIAS) : busReq.addr;
   assign addrOk = !busReq.ioAccess || (busReq.addr < `T0_IO_LIMIT);

   logic wrFlags, wrGen, wrCtlA, wrCtlB, wrCount, wrCmpA, wrCmpB, wrMask;
   assign wrFlags = busReq.wrEn && addrOk && effAddr == `T0_OFS_FLAGS;
   assign wrGen = busReq.wrEn && addrOk && effAddr == `T0_OFS_GENCTL;
   assign wrCtlA = busReq.wrEn && addrOk && effAddr == `T0_OFS_CTLA;
   assign wrCtlB = busReq.wrEn && addrOk && effAddr == `T0_OFS_CTLB;
   assign wrCount = busReq.wrEn && addrOk && effAddr == `T0_OFS_COUNT;
   assign wrCmpA = busReq.wrEn && addrOk && effAddr == `T0_OFS_CMPA;
   assign wrCmpB = busReq.wrEn && addrOk && effAddr == `T0_OFS_CMPB;
   assign wrMask = busReq.wrEn && addrOk && effAddr == `T0_OFS_MASK;
   logic [7:0] wd;
   assign wd = busReq.wrData;

   // ==========================================
   // waveform mode decode
   logic [2:0] waveMode;
   logic isPwm, isFast, isPhase, isCtc;
   logic [7:0] topValue;
   assign waveMode = {waveModeHi_r, waveModeLo_r};
   assign isFast = waveModeLo_r == `T0_WGM_LO_FAST;
   assign isPhase = waveModeLo_r == `T0_WGM_LO_PHASE;
   assign isPwm = isFast || isPhase;
   assign isCtc = waveMode == `T0_WGM_CTC;
   assign topValue = (waveModeHi_r || isCtc) ? compareValue_r[0] : `T0_MAX;

   // ==========================================
   // control register writes
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         clockSel_r <= `T0_CS_STOP;
         waveModeHi_r <= 1'b0;
         waveModeLo_r <= 2'h0;
         compareMode_r[0] <= 2'h0;
         compareMode_r[1] <= 2'h0;
         compareValue_r[0] <= `T0_RESET_BYTE;
         compareValue_r[1] <= `T0_RESET_BYTE;
         irqMask_r <= '0;
      end else if (clkEn) begin
         if (wrCtlB) begin
            clockSel_r <= wd[`T0_F_CS];
            waveModeHi_r <= wd[`T0_B_WGM_HI];
         end
         if (wrCtlA) begin
            waveModeLo_r <= wd[`T0_F_WGM_LO];
            compareMode_r[0] <= wd[`T0_F_COM_A];
            compareMode_r[1] <= wd[`T0_F_COM_B];
         end
         if (wrCmpA) begin
            compareValue_r[0] <= wd;
         end
         if (wrCmpB) begin
            compareValue_r[1] <= wd;
         end
         if (wrMask) begin
            irqMask_r <= wd[`T0_F_IRQ];
         end
      end
   end

   // ==========================================
   // general control: sync hold and prescaler resets
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         syncHold_r <= 1'b0;
         syncPrescalerRst <= 1'b0;
         asyncPrescalerRst <= 1'b0;
      end else if (clkEn) begin
         if (wrGen) begin
            syncHold_r <= wd[`T0_B_TSM];
            syncPrescalerRst <= wd[`T0_B_PSR_SYNC];
            asyncPrescalerRst <= wd[`T0_B_PSR_ASY];
         end else begin
            if (!syncHold_r) begin
               syncPrescalerRst <= 1'b0;
            end
            if (!syncHold_r && (!asyncModeActive || asyncResetDone)) begin
               asyncPrescalerRst <= 1'b0;
            end
         end
      end
   end

   // ==========================================
   // shared prescaler and tick select
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         prescale_r <= `T0_PS_ZERO;
         extPrev_r <= 1'b0;
      end else if (clkEn) begin
         prescale_r <= syncPrescalerRst ? `T0_PS_ZERO : prescale_r + `T0_PS_ONE;
         extPrev_r <= extCountPin;
      end
   end

   logic psRun, tick;
   assign psRun = !syncPrescalerRst;
   always_comb begin
      unique case (clockSel_r)
         `T0_CS_STOP: tick = 1'b0;
         `T0_CS_DIV1: tick = psRun;
         `T0_CS_DIV8: tick = psRun && (prescale_r & `T0_TAP8) == `T0_TAP8;
         `T0_CS_DIV64: tick = psRun && (prescale_r & `T0_TAP64) == `T0_TAP64;
         `T0_CS_DIV256: tick = psRun && (prescale_r & `T0_TAP256) == `T0_TAP256;
         `T0_CS_DIV1024: tick = psRun && prescale_r == `T0_TAP1024;
         `T0_CS_EXT_FALL: tick = extPrev_r && !extCountPin;
         `T0_CS_EXT_RISE: tick = !extPrev_r && extCountPin;
      endcase
   end

   // ==========================================
   // counter
   logic [1:0] match;
   logic overflowEvt, atTop;
   assign atTop = count_r == topValue;
   always_comb begin
      overflowEvt = 1'b0;
      if (tick) begin
         if (isPhase) begin
            overflowEvt = countDown_r && count_r == `T0_BOTTOM;
         end else if (isFast) begin
            overflowEvt = atTop;
         end else begin
            overflowEvt = count_r == `T0_MAX;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         count_r <= `T0_RESET_BYTE;
         countDown_r <= 1'b0;
         blockMatch_r <= 1'b0;
      end else if (clkEn) begin
         if (wrCount) begin
            count_r <= wd;
            blockMatch_r <= 1'b1;
         end else if (tick) begin
            blockMatch_r <= 1'b0;
            if (isPhase) begin
               if (!countDown_r && atTop) begin
                  countDown_r <= 1'b1;
                  count_r <= count_r - 8'h01;
               end else if (countDown_r && count_r == `T0_BOTTOM) begin
                  countDown_r <= 1'b0;
                  count_r <= count_r + 8'h01;
               end else begin
                  count_r <= countDown_r ? count_r - 8'h01 : count_r + 8'h01;
               end
            end else if ((isCtc || isFast) && atTop) begin
               count_r <= `T0_BOTTOM;
               countDown_r <= 1'b0;
            end else begin
               count_r <= count_r + 8'h01;
               countDown_r <= 1'b0;
            end
         end
      end
   end

   // ==========================================
   // compare channels
   logic [1:0] forceHit;
   assign forceHit[0] = wrCtlB && wd[`T0_B_FORCE_A] && !isPwm;
   assign forceHit[1] = wrCtlB && wd[`T0_B_FORCE_B] && !isPwm;

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_chan
         logic hit, wrapBottom;
         assign hit = tick && !blockMatch_r && count_r == compareValue_r[ch];
         assign match[ch] = hit;
         assign wrapBottom = tick && isFast && atTop;
         always_ff @(posedge core_clk) begin
            if (!reset_n) begin
               wave_r[ch] <= 1'b0;
            end else if (clkEn) begin
               if (!isPwm) begin
                  if (hit || forceHit[ch]) begin
                     unique case (compareMode_r[ch])
                        `T0_COM_TOGGLE: wave_r[ch] <= !wave_r[ch];
                        `T0_COM_CLEAR: wave_r[ch] <= 1'b0;
                        `T0_COM_SET: wave_r[ch] <= 1'b1;
                        default: wave_r[ch] <= wave_r[ch];
                     endcase
                  end
               end else if (compareMode_r[ch] == `T0_COM_TOGGLE) begin
                  if (ch == 0 && waveModeHi_r && hit) begin
                     wave_r[ch] <= !wave_r[ch];
                  end
               end else if (compareMode_r[ch][1]) begin
                  if (wrapBottom) begin
                     wave_r[ch] <= !compareMode_r[ch][0];
                  end else if (hit) begin
                     wave_r[ch] <= isFast ? compareMode_r[ch][0] : compareMode_r[ch][0] ^ countDown_r;
                  end
               end
            end
         end
      end
   endgenerate
   assign waveOutA = wave_r[0];
   assign waveOutB = wave_r[1];

   // ==========================================
   // interrupt flags and requests
   timer0_pkg::irqVec_t flagSet, flagClr;
   assign flagSet = {match[1], match[0], overflowEvt};
   assign flagClr = (wrFlags ? timer0_pkg::irqVec_t'(wd[`T0_F_IRQ]) : '0) | vectorAck;
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         irqFlags_r <= '0;
         irqReq <= '0;
      end else if (clkEn) begin
         irqFlags_r <= (irqFlags_r & ~flagClr) | flagSet;
         irqReq <= globalIrqEnable ? (irqFlags_r & irqMask_r) : '0;
      end
   end

   // ==========================================
   // read data
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         regRdData <= `T0_RESET_BYTE;
      end else if (clkEn) begin
         regRdData <= `T0_RESET_BYTE;
         if (busReq.rdEn && addrOk) begin
            unique case (effAddr)
               `T0_OFS_FLAGS: regRdData <= {5'h00, irqFlags_r};
               `T0_OFS_GENCTL: regRdData <= {syncHold_r, 5'h00, asyncPrescalerRst, syncPrescalerRst};
               `T0_OFS_CTLA: regRdData <= {compareMode_r[0], compareMode_r[1], 2'h0, waveModeLo_r};
               `T0_OFS_CTLB: regRdData <= {4'h0, waveModeHi_r, clockSel_r};
               `T0_OFS_COUNT: regRdData <= count_r;
               `T0_OFS_CMPA: regRdData <= compareValue_r[0];
               `T0_OFS_CMPB: regRdData <= compareValue_r[1];
               `T0_OFS_MASK: regRdData <= {5'h00, irqMask_r};
               default: regRdData <= `T0_RESET_BYTE;
            endcase
         end
      end
   end

   // ==========================================
   // checks
   sequence genRelease;
      clkEn && wrGen && !wd[`T0_B_TSM] && !wd[`T0_B_PSR_SYNC] && !wd[`T0_B_PSR_ASY];
   endsequence
   sequence bothCleared;
      !syncPrescalerRst && !asyncPrescalerRst;
   endsequence

   force_read_zero_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      clkEn && busReq.rdEn && addrOk && effAddr == `T0_OFS_CTLB |=> regRdData[7:6] == 2'h0)
      else $error("force bits read non-zero");
   force_pwm_ignored_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      clkEn && isPwm && compareMode_r[0] == `T0_COM_SET && !tick && wrCtlB |=> $stable(waveOutA))
      else $error("force acted in pwm mode");
   force_no_flag_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      clkEn && forceHit[0] && !match[0] && !irqFlags_r.compareA && !vectorAck.compareA |=> !irqFlags_r.compareA)
      else $error("forced compare set a flag");
   stopped_no_count_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      clockSel_r == `T0_CS_STOP && !wrCount && !wrCtlB |=> $stable(count_r))
      else $error("counter moved while stopped");
   hold_keeps_reset_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      syncHold_r && syncPrescalerRst && !wrGen |=> syncPrescalerRst [*1] ##0 prescale_r == `T0_PS_ZERO)
      else $error("reset bit dropped under sync hold");
   hold_release_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      genRelease |=> bothCleared ##0 !syncHold_r)
      else $error("reset bits not cleared on hold release");
   sync_selfclear_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      clkEn && syncPrescalerRst && !syncHold_r && !wrGen |=> !syncPrescalerRst)
      else $error("sync prescaler reset did not self-clear");
   async_wait_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      asyncPrescalerRst && asyncModeActive && !asyncResetDone && !wrGen |=> asyncPrescalerRst)
      else $error("async reset cleared before completion");
   flag_w1c_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      clkEn && wrFlags && wd[`T0_B_OVF] && !overflowEvt |=> !irqFlags_r.overflow)
      else $error("overflow flag not cleared by write one");
   flag_set_wins_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      clkEn && match[1] |=> irqFlags_r.compareB)
      else $error("compare b match lost");
   irq_gate_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      clkEn && irqFlags_r.overflow && irqMask_r.overflow && globalIrqEnable |=> irqReq.overflow)
      else $error("overflow interrupt not requested");
   irq_masked_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      clkEn && !irqMask_r.compareA |=> !irqReq.compareA)
      else $error("masked compare interrupt requested");
   write_blocks_match_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      clkEn && wrCount && clockSel_r == `T0_CS_DIV1 |=> !match[0] && !match[1])
      else $error("match not blocked after counter write");
   prescale_tap_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      clkEn && clockSel_r == `T0_CS_DIV8 && tick |=> !tick)
      else $error("divide by 8 tap longer than one cycle");

endmodule : timer0_ctrl

// file: tb/cpu_bus_model.sv
// cpu side model issuing register reads and writes to the timer block
`timescale 1ns/1ps
`include "timer0_defines.svh"
module cpu_bus_model (
   input wire logic core_clk,
   input wire logic [7:0] regRdData,
   output timer0_pkg::regReq_t busReq
);
   logic pwmActive = 1'b0;
   initial busReq = '0;
   // ==========================================
   // bus cycles
   task automatic wr(input logic [7:0] ofs, input logic io, input logic [7:0] d, input logic brk = 1'b0);
      @(posedge core_clk);
      #1;
      if (ofs == `T0_OFS_CTLA) pwmActive = d[0];
      if (ofs == `T0_OFS_CTLB && pwmActive && !brk) d[7:6] = 2'h0;
      busReq = '{1'b1, 1'b0, io, io ? ofs - `T0_IO_BIAS : ofs, d};
      @(posedge core_clk);
      #1;
      busReq = '{1'b0, 1'b0, io, ~busReq.addr, ~d};
   endtask : wr
   task automatic rd(input logic [7:0] ofs, input logic io, output logic [7:0] q);
      @(posedge core_clk);
      #1;
      busReq = '{1'b0, 1'b1, io, io ? ofs - `T0_IO_BIAS : ofs, busReq.wrData};
      @(posedge core_clk);
      #1;
      q = regRdData;
      busReq.rdEn = 1'b0;
      busReq.addr = ~busReq.addr;
   endtask : rd
endmodule : cpu_bus_model

// file: tb/timer0_control_and_prescaler_regs_bench.sv
// self-checking bench of the timer 0 control block
`timescale 1ns/1ps
`include "timer0_defines.svh"
module timer0_control_and_prescaler_regs_bench;
   logic core_clk = 1'b0;
   logic reset_n, clkEn, globalIrqEnable, asyncModeActive, asyncResetDone, extCountPin;
   timer0_pkg::irqVec_t vectorAck, irqReq;
   timer0_pkg::regReq_t busReq;
   logic [7:0] regRdData, d;
   logic waveOutA, waveOutB, asyncPrescalerRst, syncPrescalerRst;
   logic [7:0] lfsrState = 8'h5d; // seed 93
   logic [7:0] ofsList [8] = '{8'h35, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47, 8'h48, 8'h6e};
   logic [1:0] comList [3] = '{`T0_COM_CLEAR, `T0_COM_SET, `T0_COM_TOGGLE};
   int failures = 0;
   int tests_run = 0;
   always #25 core_clk = ~core_clk;
   timer0_ctrl timer0_ctrl_i (.core_clk(core_clk), .reset_n(reset_n), .clkEn(clkEn), .busReq(busReq),
      .globalIrqEnable(globalIrqEnable), .vectorAck(vectorAck), .asyncModeActive(asyncModeActive),
      .asyncResetDone(asyncResetDone), .extCountPin(extCountPin), .regRdData(regRdData), .irqReq(irqReq),
      .waveOutA(waveOutA), .waveOutB(waveOutB), .asyncPrescalerRst(asyncPrescalerRst),
      .syncPrescalerRst(syncPrescalerRst));
   cpu_bus_model cpu_i (.core_clk(core_clk), .regRdData(regRdData), .busReq(busReq));
   // ==========================================
   // expectations and checks
   function automatic logic [7:0] lfsr_next();
      lfsrState = {lfsrState[6:0], lfsrState[7] ^ lfsrState[5] ^ lfsrState[4] ^ lfsrState[3]};
      return lfsrState;
   endfunction : lfsr_next
   function automatic int div_of(int c);
      case (c)
         1: return 1;
         2: return 8;
         3: return 64;
         4: return 256;
         default: return 1024;
      endcase
   endfunction : div_of
   function automatic int span_of(int c);
      return div_of(c) == 1 ? 40 : 4 * div_of(c) + div_of(c) / 2;
   endfunction : span_of
   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check_byte
   task automatic check_near(input logic [7:0] got, input logic [7:0] exp, input string what);
      tests_run++;
      if ((^got) === 1'bx || got > exp + 8'h02 || got + 8'h02 < exp) begin
         failures++;
         $display("ERROR at %0t: %s got %h expected about %h", $time, what, got, exp);
      end
   endtask : check_near
   task automatic rdchk(input logic [7:0] ofs, input logic io, input logic [7:0] exp, input string what);
      logic [7:0] q;
      cpu_i.rd(ofs, io, q);
      check_byte(q, exp, what);
   endtask : rdchk
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : cyc
   task automatic test_done(input string name);
      $display("test %s done at %0t", name, $time);
   endtask : test_done
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_of_test
   // ==========================================
   // watchdog
   initial begin
      repeat (40000) @(posedge core_clk);
      failures++;
      $display("ERROR at %0t: watchdog expired", $time);
      end_of_test();
   end
   // ==========================================
   // main sequence
   initial begin
      reset_n = 1'b0;
      clkEn = 1'b1;
      globalIrqEnable = 1'b0;
      vectorAck = '0;
      asyncModeActive = 1'b0;
      asyncResetDone = 1'b0;
      extCountPin = 1'b0;
      cyc(20);
      reset_n = 1'b1;
      foreach (ofsList[i]) rdchk(ofsList[i], 1'b0, `T0_RESET_BYTE, "reset value");
      rdchk(8'h49, 1'b0, 8'h00, "unmapped");
      for (int i = 0; i < 4; i++) begin
         d = lfsr_next();
         cpu_i.wr(`T0_OFS_CMPA, 1'b1, d);
         cpu_i.wr(`T0_OFS_CMPB, 1'b0, ~d);
         cpu_i.wr(`T0_OFS_COUNT, i[0], d ^ 8'h5a);
         cpu_i.wr(`T0_OFS_MASK, 1'b0, d);
         cpu_i.wr(`T0_OFS_MASK, 1'b1, ~d);
         rdchk(`T0_OFS_CMPA, 1'b0, d, "compare a");
         rdchk(`T0_OFS_CMPB, 1'b1, ~d, "compare b");
         rdchk(`T0_OFS_COUNT, ~i[0], d ^ 8'h5a, "count");
         rdchk(`T0_OFS_MASK, 1'b0, d & 8'h07, "mask, io alias refused");
      end
      clkEn = 1'b0;
      cpu_i.wr(`T0_OFS_CMPA, 1'b0, ~d);
      clkEn = 1'b1;
      rdchk(`T0_OFS_CMPA, 1'b0, d, "write while frozen");
      test_done("registers");
      cpu_i.wr(`T0_OFS_GENCTL, 1'b0, 8'h83);
      cpu_i.wr(`T0_OFS_COUNT, 1'b0, 8'h00);
      cpu_i.wr(`T0_OFS_CTLB, 1'b0, `T0_CS_DIV1);
      cyc(20);
      check_byte({6'h00, asyncPrescalerRst, syncPrescalerRst}, 8'h03, "reset outputs held");
      rdchk(`T0_OFS_GENCTL, 1'b0, 8'h83, "hold keeps resets");
      rdchk(`T0_OFS_COUNT, 1'b1, 8'h00, "held counter");
      cpu_i.wr(`T0_OFS_GENCTL, 1'b1, 8'h00);
      rdchk(`T0_OFS_GENCTL, 1'b0, 8'h00, "hold release");
      for (int c = 1; c <= 5; c++) begin
         cpu_i.wr(`T0_OFS_GENCTL, 1'b0, 8'h81);
         cpu_i.wr(`T0_OFS_COUNT, 1'b0, 8'h00);
         cpu_i.wr(`T0_OFS_CTLB, 1'b0, c[7:0]);
         cpu_i.wr(`T0_OFS_GENCTL, 1'b0, 8'h00);
         cyc(span_of(c));
         cpu_i.rd(`T0_OFS_COUNT, 1'b0, d);
         check_near(d, div_of(c) == 1 ? 8'h2a : 8'h04, "prescaled count");
      end
      cpu_i.wr(`T0_OFS_CTLB, 1'b0, `T0_CS_STOP);
      cpu_i.rd(`T0_OFS_COUNT, 1'b0, d);
      cyc(20);
      rdchk(`T0_OFS_COUNT, 1'b0, d, "stopped count");
      cpu_i.wr(`T0_OFS_GENCTL, 1'b0, 8'h01);
      rdchk(`T0_OFS_GENCTL, 1'b0, 8'h00, "sync reset self clear");
      asyncModeActive = 1'b1;
      cpu_i.wr(`T0_OFS_GENCTL, 1'b0, 8'h02);
      cyc(3);
      rdchk(`T0_OFS_GENCTL, 1'b0, 8'h02, "async reset waits");
      asyncResetDone = 1'b1;
      cyc(2);
      rdchk(`T0_OFS_GENCTL, 1'b0, 8'h00, "async reset done");
      asyncModeActive = 1'b0;
      asyncResetDone = 1'b0;
      test_done("prescaler");
      for (int c = 6; c <= 7; c++) begin
         extCountPin = 1'b0;
         cpu_i.wr(`T0_OFS_COUNT, 1'b0, 8'h00);
         cpu_i.wr(`T0_OFS_CTLB, 1'b0, c[7:0]);
         repeat (9) begin
            cyc(3);
            extCountPin = ~extCountPin;
         end
         cyc(3);
         cpu_i.wr(`T0_OFS_CTLB, 1'b0, `T0_CS_STOP);
         rdchk(`T0_OFS_COUNT, 1'b0, c == 7 ? 8'h05 : 8'h04, "pin edges");
      end
      test_done("external pin");
      globalIrqEnable = 1'b1;
      cpu_i.wr(`T0_OFS_MASK, 1'b0, 8'h07);
      foreach (comList[i]) begin
         cpu_i.wr(`T0_OFS_CTLA, 1'b0, {comList[i], comList[i], 4'h0});
         cpu_i.wr(`T0_OFS_CTLB, 1'b0, 8'hc0);
         check_byte({6'h00, waveOutA, waveOutB}, i == 1 ? 8'h03 : 8'h00, "forced output");
      end
      rdchk(`T0_OFS_CTLB, 1'b0, 8'h00, "force bits read");
      cpu_i.wr(`T0_OFS_CMPA, 1'b0, 8'h05);
      cpu_i.wr(`T0_OFS_COUNT, 1'b0, 8'h05);
      cpu_i.wr(`T0_OFS_CTLA, 1'b0, 8'h52);
      cpu_i.wr(`T0_OFS_CTLB, 1'b0, 8'hc0);
      check_byte({6'h00, waveOutA, waveOutB}, 8'h03, "forced toggle");
      rdchk(`T0_OFS_COUNT, 1'b0, 8'h05, "forced match keeps count");
      rdchk(`T0_OFS_FLAGS, 1'b0, 8'h00, "forced match flags");
      check_byte({5'h00, irqReq}, 8'h00, "forced match irq");
      for (int m = 1; m <= 3; m += 2) begin
         cpu_i.wr(`T0_OFS_CTLA, 1'b0, 8'hf0 | m[7:0]);
         cpu_i.wr(`T0_OFS_CTLB, 1'b0, 8'hc0, 1'b1);
         check_byte({6'h00, waveOutA, waveOutB}, 8'h03, "force in pwm");
      end
      test_done("force");
      cpu_i.wr(`T0_OFS_CTLA, 1'b0, 8'h50);
      cpu_i.wr(`T0_OFS_FLAGS, 1'b0, 8'h07);
      cpu_i.wr(`T0_OFS_CMPA, 1'b0, 8'hf4);
      cpu_i.wr(`T0_OFS_CMPB, 1'b0, 8'hf8);
      cpu_i.wr(`T0_OFS_COUNT, 1'b0, 8'hf0);
      cpu_i.wr(`T0_OFS_CTLB, 1'b0, `T0_CS_DIV1);
      cyc(30);
      cpu_i.wr(`T0_OFS_CTLB, 1'b0, `T0_CS_STOP);
      rdchk(`T0_OFS_FLAGS, 1'b1, 8'h07, "match and overflow flags");
      check_byte({6'h00, waveOutA, waveOutB}, 8'h00, "match toggles");
      check_byte({5'h00, irqReq}, 8'h07, "all irqs");
      cpu_i.wr(`T0_OFS_MASK, 1'b0, 8'h02);
      cyc(2);
      check_byte({5'h00, irqReq}, 8'h02, "masked irqs");
      globalIrqEnable = 1'b0;
      cyc(2);
      check_byte({5'h00, irqReq}, 8'h00, "global off");
      cpu_i.wr(`T0_OFS_FLAGS, 1'b0, 8'h01);
      cpu_i.wr(`T0_OFS_FLAGS, 1'b1, 8'h00);
      rdchk(`T0_OFS_FLAGS, 1'b0, 8'h06, "write one clears");
      vectorAck = 3'h2;
      cyc(1);
      vectorAck = '0;
      rdchk(`T0_OFS_FLAGS, 1'b0, 8'h04, "vector clears");
      cpu_i.wr(`T0_OFS_FLAGS, 1'b0, 8'h07);
      cpu_i.wr(`T0_OFS_CMPA, 1'b0, 8'h20);
      cpu_i.wr(`T0_OFS_COUNT, 1'b0, 8'h10);
      cpu_i.wr(`T0_OFS_CTLB, 1'b0, `T0_CS_DIV1);
      cpu_i.wr(`T0_OFS_COUNT, 1'b0, 8'h20);
      cpu_i.wr(`T0_OFS_CTLB, 1'b0, `T0_CS_STOP);
      rdchk(`T0_OFS_FLAGS, 1'b0, 8'h00, "count write blocks match");
      check_byte({6'h00, waveOutA, waveOutB}, 8'h00, "blocked match output");
      test_done("compare");
      end_of_test();
   end
endmodule : timer0_control_and_prescaler_regs_bench
